// >>> test_wdt_timer.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module test_wdt_timer;
  logic clk_sys = 1'h0, rst = 1'h1, in_en = 1'h0, md_a = 1'h0, md_b = 1'h0, single = 1'h0;
  logic out_en = 1'h0, out_md = 1'h0, out_val = 1'h0, wd_en = 1'h0, run_set = 1'h0;
  logic run_clear = 1'h0, hi_wr = 1'h0, lo_wr = 1'h0, fall_req = 1'h0;
  logic [7:0] wr_data = 8'h00;
  logic run_bit, pin_in, pin_out, eoc, wd_rst;
  logic [15:0] count_value;
  int n_fail = 0, checks_done = 0, cycles = 0;
  always #12.5 clk_sys = ~clk_sys;
  wdt_pin_src SRC (.clk_sys(clk_sys), .fall_req(fall_req), .count_input_pin(pin_in));
  wdt_timer DUT (.clk_sys(clk_sys), .rst(rst), .input_enable_bit(in_en),
    .input_mode_bit_a(md_a), .input_mode_bit_b(md_b), .single_mode_bit(single),
    .output_enable_bit(out_en), .output_mode_bit(out_md), .output_value_bit(out_val),
    .watchdog_enable_bit(wd_en), .run_set(run_set), .run_clear(run_clear),
    .run_bit(run_bit), .reload_high_wr(hi_wr), .reload_low_wr(lo_wr), .wr_data(wr_data),
    .count_input_pin(pin_in), .timer_output_pin(pin_out), .count_value(count_value),
    .end_of_count(eoc), .watchdog_reset(wd_rst));
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task load(input logic [15:0] v);
    @(posedge clk_sys);
    hi_wr <= 1'h1;
    wr_data <= v[15:8];
    @(posedge clk_sys);
    hi_wr <= 1'h0;
    lo_wr <= 1'h1;
    wr_data <= v[7:0];
    @(posedge clk_sys);
    lo_wr <= 1'h0;
  endtask : load
  // starts counting and checks the latch copy one cycle after run rises
  task start(input logic [15:0] v);
    @(posedge clk_sys);
    run_set <= 1'h1;
    @(posedge clk_sys);
    run_set <= 1'h0;
    #1 `CHK(run_bit, 1'h1)
    @(posedge clk_sys);
    #1 `CHK(count_value, v)
  endtask : start
  // bounded wait for a one-cycle pulse; sel 1 waits for watchdog reset
  // always lets one edge pass first so a pulse just seen is not counted twice
  task wait_hi(input logic sel, input int lim);
    int k;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      #1 k++;
    end
    while ((sel ? wd_rst : eoc) !== 1'h1 && k < lim);
    `CHK(sel ? wd_rst : eoc, 1'h1)
  endtask : wait_hi
  // one write of the low reload byte
  task wr_lo(input logic [7:0] v);
    @(posedge clk_sys);
    lo_wr <= 1'h1;
    wr_data <= v;
    @(posedge clk_sys);
    lo_wr <= 1'h0;
  endtask : wr_lo
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      conclude();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'h0;
    #1 `CHK({run_bit, pin_out, count_value}, 18'h0ffff)
    single <= 1'h1;
    out_en <= 1'h1;
    out_md <= 1'h1;
    load(16'h0003);
    start(16'h0003);
    wait_hi(1'h0, 30);
    `CHK({run_bit, pin_out}, 2'h1)
    `CHK(count_value, 16'h0003)
    single <= 1'h0;
    out_md <= 1'h0;
    start(16'h0003);
    wait_hi(1'h0, 30);
    `CHK({run_bit, pin_out, count_value}, 18'h20003)
    wait_hi(1'h0, 30);
    run_clear <= 1'h1;
    in_en <= 1'h1;
    load(16'h0010);
    run_clear <= 1'h0;
    start(16'h0010);
    repeat (2)
    begin
      fall_req <= 1'h1;
      @(posedge clk_sys);
      fall_req <= 1'h0;
      repeat (20) @(posedge clk_sys);
    end
    #1 `CHK(count_value, 16'h000e)
    @(posedge clk_sys);
    run_clear <= 1'h1;
    in_en <= 1'h0;
    wd_en <= 1'h1;
    load(16'h0002);
    run_clear <= 1'h0;
    start(16'h0002);
    wait_hi(1'h1, 20);
    wr_lo(8'haa);
    wr_lo(8'h55);
    #1 `CHK(count_value, 16'h00aa)
    run_clear <= 1'h1;
    wd_en <= 1'h0;
    in_en <= 1'h1;
    md_a <= 1'h1;
    load(16'h0010);
    run_clear <= 1'h0;
    start(16'h0010);
    repeat (12) @(posedge clk_sys);
    #1 `CHK(count_value, 16'h0010)
    conclude();
  end
endmodule : test_wdt_timer

// >>> wdt_cfg.svh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
// ----------------------------------------
// timing and widths
// ----------------------------------------
`define WDT_CNT_W 16
`define WDT_DIV 2'h3
`define WDT_ZERO 16'h0000
`define WDT_ONE 16'h0001
`define WDT_KEY_A 8'haa
`define WDT_KEY_B 8'h55
`endif

// >>> wdt_pin_src.sv
`timescale 1ns/10ps
// ----------------------------------------
// pulse source on the count input pin
// ----------------------------------------
module wdt_pin_src (
  // clock
  input wire logic clk_sys,
  // request one falling edge
  input wire logic fall_req,
  // pin
  output logic count_input_pin
);
  logic [3:0] low_ff = 4'h0;
  // held low eight clocks so the three-stage synchroniser cannot miss it
  always_ff @(posedge clk_sys)
  begin
    if (fall_req)
      low_ff <= 4'h8;
    else if (low_ff != 4'h0)
      low_ff <= low_ff - 4'h1;
  end
  assign count_input_pin = (low_ff == 4'h0);
endmodule : wdt_pin_src

// >>> wdt_pkg.sv
package wdt_pkg;
  typedef enum logic [1:0] {WDT_EVENT, WDT_GATED, WDT_RETRIG, WDT_TRIG} wdt_mode_t;
  typedef enum {WDT_KEY_IDLE, WDT_KEY_GOT_A} wdt_key_t;
endpackage : wdt_pkg

// >>> wdt_timer.sv
`timescale 1ns/10ps
`include "wdt_cfg.svh"
// How it works
// - enable bit and two mode bits pick event, gated, retrigger, trigger or clock
// - internal clock source decrements once every four system clocks
// - event mode decrements on each input falling edge while run bit set
// - gated mode decrements at divided rate while input and run both high
// - retrigger mode reloads on run rising edge and input falls while running
// - trigger mode loads on first input fall, then counts; later edges ignored
// - every underflow reloads counter from the software reload latch
// - single-shot mode clears run bit at end of count
// - continuous mode reloads and keeps counting at end of count
// - run bit rising edge copies latch into counter
// - output pin changes at end of count only when output enabled
// - output mode picks copy of output value bit or inversion of the current pin level
// - end of count pulses a borrowed interrupt request, no vector here
// - output pin and interrupt request change on the same event
// - watchdog counter reaching zero raises a system reset request
module wdt_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control bits
  input wire logic input_enable_bit,
  input wire logic input_mode_bit_a,
  input wire logic input_mode_bit_b,
  input wire logic single_mode_bit,
  input wire logic output_enable_bit,
  input wire logic output_mode_bit,
  input wire logic output_value_bit,
  input wire logic watchdog_enable_bit,
  // run bit: software set pulse, read back level
  input wire logic run_set,
  input wire logic run_clear,
  output logic run_bit,
  // reload byte writes
  input wire logic reload_high_wr,
  input wire logic reload_low_wr,
  input wire logic [7:0] wr_data,
  // pins
  input wire logic count_input_pin,
  output logic timer_output_pin,
  // status
  output logic [15:0] count_value,
  output logic end_of_count,
  output logic watchdog_reset
);
  // ----------------------------------------
  // input synchroniser and edge detect
  // ----------------------------------------
  logic [2:0] pin_sync_ff;
  logic pin_lvl_ff;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_sync_ff <= 3'h7;
      pin_lvl_ff <= 1'h1;
    end
    else
    begin
      pin_sync_ff <= {pin_sync_ff[1:0], count_input_pin};
      if (pin_sync_ff[1] == pin_sync_ff[2])
        pin_lvl_ff <= pin_sync_ff[2];
    end
  end
  wire pin_agree = (pin_sync_ff[1] == pin_sync_ff[2]);
  wire pin_fall = pin_agree & pin_lvl_ff & ~pin_sync_ff[2];
  wire pin_high = pin_lvl_ff;

  // ----------------------------------------
  // mode decode and prescaler
  // ----------------------------------------
  wdt_pkg::wdt_mode_t mode;
  assign mode = wdt_pkg::wdt_mode_t'({input_mode_bit_a, input_mode_bit_a ^ input_mode_bit_b});
  // 00 event, 01 gated, 11 retrig (enc 10), 10 trig (enc 11)
  wire m_event = input_enable_bit & (mode == wdt_pkg::WDT_EVENT);
  wire m_gated = input_enable_bit & (mode == wdt_pkg::WDT_GATED);
  wire m_retrig = input_enable_bit & (mode == wdt_pkg::WDT_RETRIG);
  wire m_trig = input_enable_bit & (mode == wdt_pkg::WDT_TRIG);

  logic [1:0] div_ff;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      div_ff <= 2'h0;
    else
      div_ff <= div_ff + 2'h1;
  end
  wire div_tick = (div_ff == `WDT_DIV);

  // ----------------------------------------
  // run bit, latch, counter
  // ----------------------------------------
  logic run_ff;
  logic run_d_ff;
  logic armed_ff;
  logic [15:0] latch_ff;
  logic [15:0] cnt_ff;
  logic out_ff;
  logic eoc_ff;
  logic wdr_ff;
  wdt_pkg::wdt_key_t key_ff;

  wire run_rise = run_ff & ~run_d_ff;
  wire dec = run_ff & ~run_rise & (
    (m_event & pin_fall) |
    (m_gated & pin_high & div_tick) |
    (m_retrig & div_tick) |
    (m_trig & armed_ff & div_tick) |
    (~input_enable_bit & div_tick));
  wire eoc = dec & (cnt_ff == `WDT_ZERO);
  wire retrig_load = m_retrig & run_ff & pin_fall;
  wire trig_load = m_trig & run_ff & ~armed_ff & pin_fall;
  wire load = run_rise | retrig_load | trig_load | eoc;
  wire wd_zero = watchdog_enable_bit & dec & (cnt_ff == `WDT_ONE);
  wire key_ok = reload_low_wr & (wr_data == `WDT_KEY_B) & (key_ff == wdt_pkg::WDT_KEY_GOT_A);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      run_ff <= 1'h0;
      run_d_ff <= 1'h0;
    end
    else
    begin
      // single-shot end of count wins over a software set in the same cycle
      if (eoc & single_mode_bit)
        run_ff <= 1'h0;
      else if (run_set)
        run_ff <= 1'h1;
      else if (run_clear)
        run_ff <= 1'h0;
      run_d_ff <= run_ff;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      armed_ff <= 1'h0;
    else if (~run_ff | ~m_trig)
      armed_ff <= 1'h0;
    else if (trig_load)
      armed_ff <= 1'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      latch_ff <= 16'hffff;
    else if (reload_high_wr)
      latch_ff <= {wr_data, latch_ff[7:0]};
    else if (reload_low_wr)
      latch_ff <= {latch_ff[15:8], wr_data};
  end

  // key sequence restarts the watchdog count from the latch
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      key_ff <= wdt_pkg::WDT_KEY_IDLE;
    else if (reload_low_wr)
      key_ff <= (wr_data == `WDT_KEY_A) ? wdt_pkg::WDT_KEY_GOT_A : wdt_pkg::WDT_KEY_IDLE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt_ff <= 16'hffff;
    else if (load | (watchdog_enable_bit & key_ok))
      cnt_ff <= latch_ff;
    else if (dec)
      cnt_ff <= cnt_ff - `WDT_ONE;
  end

  // ----------------------------------------
  // output pin and end of count
  // ----------------------------------------
  wire nxt_out = output_mode_bit ? ~out_ff : output_value_bit;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      out_ff <= 1'h0;
      eoc_ff <= 1'h0;
      wdr_ff <= 1'h0;
    end
    else
    begin
      if (eoc & output_enable_bit)
        out_ff <= nxt_out;
      eoc_ff <= eoc;
      wdr_ff <= wd_zero;
    end
  end

  assign run_bit = run_ff;
  assign timer_output_pin = out_ff;
  assign count_value = cnt_ff;
  assign end_of_count = eoc_ff;
  assign watchdog_reset = wdr_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_eoc_single;
    eoc & single_mode_bit;
  endsequence
  a_clock_div_rate: assert property (dec & ~input_enable_bit |-> ##1 !dec [*3])
    else $error("clock source decremented faster than one in four");
  a_event_edge: assert property (m_event & dec |-> pin_fall)
    else $error("event decrement without input fall");
  a_gated_low: assert property (m_gated & ~pin_high |-> !dec)
    else $error("gated count while input low");
  a_run_rise_load: assert property ($rose(run_ff) |=> cnt_ff == $past(latch_ff))
    else $error("run start did not load latch");
  a_eoc_reload: assert property (eoc & ~run_rise |=> cnt_ff == $past(latch_ff))
    else $error("underflow did not reload");
  a_single_stop: assert property (s_eoc_single |=> !run_ff)
    else $error("single shot did not stop");
  a_cont_keep: assert property (eoc & ~single_mode_bit & ~run_clear |=> run_ff)
    else $error("continuous mode stopped");
  a_out_hold: assert property (!eoc_ff |-> $stable(out_ff) or $past(rst))
    else $error("output moved without end of count");
  a_out_toggle: assert property (eoc & output_enable_bit & output_mode_bit |=> out_ff != $past(out_ff))
    else $error("output did not invert");
  a_irq_with_out: assert property (eoc & output_enable_bit |=> end_of_count)
    else $error("request not with output update");
  a_trig_once: assert property (m_trig & armed_ff & run_ff & pin_fall & ~dec |=> $stable(cnt_ff))
    else $error("trigger mode reloaded twice");
  a_wd_reset: assert property (wd_zero |=> watchdog_reset)
    else $error("watchdog zero without reset");
endmodule : wdt_timer
